// *** verilog/flag_offset_pkg.sv ***
// constants for the programmable flag offset block
// assumes one 200 MHz clock; write and read strobes sampled on it
package flag_offset_pkg;

  // ==========================================================================
  // geometry
  localparam int OFS_W = 13;
  localparam int SER_BITS = 26;
  localparam int SIDX_W = 5;
  localparam logic [SIDX_W-1:0] SER_LAST = 5'h19;
  localparam int DATA_W = 18;
  localparam int CNT_W = 14;
  localparam logic [CNT_W-1:0] DEPTH_WORDS = 14'h2000;

  // ==========================================================================
  // default offsets chosen at master reset
  localparam logic [OFS_W-1:0] PAR_DEFAULT = 13'h007F;
  localparam logic [OFS_W-1:0] SER_DEFAULT = 13'h03FF;

  // ==========================================================================
  // flag validity delays
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CLOCK_SKEW_NS = 5;
  localparam int SKEW_CYC_RAW = (CLOCK_SKEW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SKEW_CYC = (SKEW_CYC_RAW < 1) ? 1 : SKEW_CYC_RAW;
  localparam int AF_EDGES = 2;
  localparam int AE_EDGES = 2;
  localparam logic [2:0] AF_LOAD = 3'(AF_EDGES);
  localparam logic [2:0] AE_LOAD = 3'(AE_EDGES + SKEW_CYC);

  // ==========================================================================
  // register map (byte addresses)
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h004;
  localparam logic [ADDR_W-1:0] EMPTY_OFS_ADDR = 12'h008;
  localparam logic [ADDR_W-1:0] FULL_OFS_ADDR = 12'h00C;

  // control fields
  localparam int CTRL_FLAG_EN_BIT = 0;
  localparam logic CTRL_FLAG_EN_RST = 1'b1;

  // status fields
  localparam int ST_SERIAL_BIT = 0;
  localparam int ST_FIRST_WORD_FALL_THROUGH_BIT = 1;
  localparam int ST_AE_VLD_BIT = 2;
  localparam int ST_AF_VLD_BIT = 3;
  localparam int ST_WPTR_BIT = 4;
  localparam int ST_RPTR_BIT = 5;
  localparam int ST_SIDX_LSB = 8;

endpackage

// *** verilog/flag_offset_ctrl.sv ***
// programmable almost-empty / almost-full offset logic with apb status
// assumes all pins synchronous to clk_in; word count comes from the datapath
//
// How it works
// - master reset loads 127 parallel, 1023 serial
// - load method latched only at master reset
// - serial shift lsb-first while load and shift low
// - serial sequence is 26 bits for both
// - serial loads both registers; flags valid after all
// - no serial capture when shift enable high
// - paused serial load resumes at next bit
// - almost-full valid two write edges after load
// - almost-empty valid two read edges plus skew
// - offsets readable only in parallel on output
// - first parallel write goes to empty offset
// - master reset points both pointers at empty
// - partial reset leaves both pointers alone
// - load high writes memory; offsets resume sequence
// - each flag invalid until its word written
// - readback order empty, full, empty, repeating
// - interrupted readback resumes at next register
// - offset read replaces the output data word
// - readback allowed in every timing and load mode
// - load high at reset selects serial, else parallel
// - fall-through: almost-empty low at offset plus one
`timescale 1ns/1ps
`default_nettype none

module flag_offset_ctrl
  import flag_offset_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // device resets and mode strap
  input wire logic master_reset_n_in,
  input wire logic partial_reset_n_in,
  input wire logic first_word_fall_through_in,
  // programming pins
  input wire logic offset_load_n_in,
  input wire logic serial_shift_enable_n_in,
  input wire logic write_enable_n_in,
  input wire logic read_enable_n_in,
  input wire logic serial_offset_in,
  input wire logic [DATA_W-1:0] data_in_bus_in,
  // memory datapath
  input wire logic [DATA_W-1:0] mem_rd_data_in,
  input wire logic [CNT_W-1:0] word_count_in,
  output logic mem_wr_out,
  output logic mem_rd_out,
  output logic [DATA_W-1:0] mem_wr_data_out,
  // outputs
  output logic [DATA_W-1:0] data_out_bus_out,
  output logic almost_empty_n_out,
  output logic almost_full_n_out,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr
);

  // ==========================================================================
  // state
  logic serial_q;
  logic first_word_fall_through_q;
  logic [2*OFS_W-1:0] offs_q;
  logic [SIDX_W-1:0] sidx_q;
  logic wptr_q;
  logic rptr_q;
  logic ae_vld_q;
  logic af_vld_q;
  logic [2:0] ae_cnt_q;
  logic [2:0] af_cnt_q;
  logic flag_en_q;
  logic [DATA_W-1:0] data_out_q;
  logic ae_n_q;
  logic af_n_q;
  logic mem_wr_q;
  logic mem_rd_q;
  logic [DATA_W-1:0] mem_wr_data_q;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  // ==========================================================================
  // operation decode
  logic run;
  logic ser_shift;
  logic par_wr;
  logic off_rd;
  logic mem_wr;
  logic mem_rd;
  logic ser_start;
  logic ser_done;
  logic par_empty_wr;
  logic par_full_wr;
  logic [OFS_W-1:0] empty_ofs;
  logic [OFS_W-1:0] full_ofs;

  assign run = master_reset_n_in && partial_reset_n_in;
  // serial only when latched serial, load and shift both low
  assign ser_shift = run && serial_q && !offset_load_n_in && !serial_shift_enable_n_in;
  // parallel only when latched parallel
  assign par_wr = run && !serial_q && !offset_load_n_in && !write_enable_n_in;
  // readback in any mode
  assign off_rd = run && !offset_load_n_in && !read_enable_n_in;
  assign mem_wr = run && offset_load_n_in && !write_enable_n_in;
  assign mem_rd = run && offset_load_n_in && !read_enable_n_in;
  assign ser_start = ser_shift && (sidx_q == '0);
  assign ser_done = ser_shift && (sidx_q == SER_LAST);
  assign par_empty_wr = par_wr && !wptr_q;
  assign par_full_wr = par_wr && wptr_q;
  assign empty_ofs = offs_q[OFS_W-1:0];
  assign full_ofs = offs_q[2*OFS_W-1:OFS_W];

  // ==========================================================================
  // load method and timing mode strap
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      serial_q <= 1'b0;
      first_word_fall_through_q <= 1'b0;
    end
    else if (!master_reset_n_in)
    begin
      serial_q <= offset_load_n_in;
      first_word_fall_through_q <= first_word_fall_through_in;
    end
  end

  // ==========================================================================
  // offset registers
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      offs_q <= {PAR_DEFAULT, PAR_DEFAULT};
    end
    else if (!master_reset_n_in)
    begin
      if (offset_load_n_in)
      begin
        offs_q <= {SER_DEFAULT, SER_DEFAULT};
      end
      else
      begin
        offs_q <= {PAR_DEFAULT, PAR_DEFAULT};
      end
    end
    else if (ser_shift)
    begin
      offs_q[sidx_q] <= serial_offset_in;
    end
    else if (par_wr)
    begin
      offs_q[wptr_q*OFS_W +: OFS_W] <= data_in_bus_in[OFS_W-1:0];
    end
  end

  // ==========================================================================
  // serial bit index
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || !master_reset_n_in)
    begin
      sidx_q <= '0;
    end
    else if (ser_shift)
    begin
      // a paused shift simply holds the index
      if (sidx_q == SER_LAST)
      begin
        sidx_q <= '0;
      end
      else
      begin
        sidx_q <= sidx_q + 5'h01;
      end
    end
  end

  // ==========================================================================
  // offset write and read pointers
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || !master_reset_n_in)
    begin
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
    end
    else
    begin
      // partial reset blocks ops, so pointers stay put
      if (par_wr)
      begin
        wptr_q <= !wptr_q;
      end
      if (off_rd)
      begin
        rptr_q <= !rptr_q;
      end
    end
  end

  // ==========================================================================
  // flag validity tracking
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || !master_reset_n_in)
    begin
      ae_vld_q <= 1'b1;
      af_vld_q <= 1'b1;
      ae_cnt_q <= '0;
      af_cnt_q <= '0;
    end
    else
    begin
      if (ser_done || par_empty_wr)
      begin
        ae_vld_q <= 1'b0;
        ae_cnt_q <= AE_LOAD;
      end
      else if (ser_start)
      begin
        ae_vld_q <= 1'b0;
        ae_cnt_q <= '0;
      end
      else if (ae_cnt_q != '0)
      begin
        ae_cnt_q <= ae_cnt_q - 3'h1;
        if (ae_cnt_q == 3'h1)
        begin
          ae_vld_q <= 1'b1;
        end
      end
      if (ser_done || par_full_wr)
      begin
        af_vld_q <= 1'b0;
        af_cnt_q <= AF_LOAD;
      end
      else if (ser_start || par_empty_wr)
      begin
        af_vld_q <= 1'b0;
        af_cnt_q <= '0;
      end
      else if (af_cnt_q != '0)
      begin
        af_cnt_q <= af_cnt_q - 3'h1;
        if (af_cnt_q == 3'h1)
        begin
          af_vld_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // partial flags, held while their offset is invalid
  logic [CNT_W-1:0] ae_thr;
  logic [CNT_W-1:0] af_thr;

  always_comb
  begin
    ae_thr = CNT_W'(empty_ofs) + (first_word_fall_through_q ? 14'h0002 : 14'h0001);
    af_thr = DEPTH_WORDS + {13'h0000, first_word_fall_through_q} - CNT_W'(full_ofs);
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || !master_reset_n_in || !partial_reset_n_in)
    begin
      ae_n_q <= 1'b0;
      af_n_q <= 1'b1;
    end
    else
    begin
      if (!flag_en_q)
      begin
        ae_n_q <= 1'b1;
      end
      else if (ae_vld_q)
      begin
        ae_n_q <= (word_count_in >= ae_thr);
      end
      if (!flag_en_q)
      begin
        af_n_q <= 1'b1;
      end
      else if (af_vld_q)
      begin
        af_n_q <= !(word_count_in >= af_thr);
      end
    end
  end

  // ==========================================================================
  // output word and memory strobes
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || !master_reset_n_in || !partial_reset_n_in)
    begin
      data_out_q <= '0;
    end
    else if (off_rd)
    begin
      data_out_q <= DATA_W'(rptr_q ? full_ofs : empty_ofs);
    end
    else if (mem_rd)
    begin
      data_out_q <= mem_rd_data_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      mem_wr_q <= 1'b0;
      mem_rd_q <= 1'b0;
      mem_wr_data_q <= '0;
    end
    else
    begin
      mem_wr_q <= mem_wr;
      mem_rd_q <= mem_rd;
      mem_wr_data_q <= data_in_bus_in;
    end
  end

  // ==========================================================================
  // apb slave: answer in the second access cycle
  logic apb_acc;
  logic addr_ok;
  logic [31:0] rd_mux;

  assign apb_acc = psel && penable && pready_q;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      CTRL_ADDR: rd_mux[CTRL_FLAG_EN_BIT] = flag_en_q;
      STATUS_ADDR:
      begin
        rd_mux[ST_SERIAL_BIT] = serial_q;
        rd_mux[ST_FIRST_WORD_FALL_THROUGH_BIT] = first_word_fall_through_q;
        rd_mux[ST_AE_VLD_BIT] = ae_vld_q;
        rd_mux[ST_AF_VLD_BIT] = af_vld_q;
        rd_mux[ST_WPTR_BIT] = wptr_q;
        rd_mux[ST_RPTR_BIT] = rptr_q;
        rd_mux[ST_SIDX_LSB +: SIDX_W] = sidx_q;
      end
      EMPTY_OFS_ADDR: rd_mux[OFS_W-1:0] = empty_ofs;
      FULL_OFS_ADDR: rd_mux[OFS_W-1:0] = full_ofs;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= psel && penable && !pready_q;
      if (psel && penable && !pready_q)
      begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_q <= !addr_ok;
      end
      else
      begin
        prdata_q <= '0;
        pslverr_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      flag_en_q <= CTRL_FLAG_EN_RST;
    end
    else if (apb_acc && pwrite && (paddr == CTRL_ADDR))
    begin
      flag_en_q <= pwdata[CTRL_FLAG_EN_BIT];
    end
  end

  // ==========================================================================
  // outputs
  assign data_out_bus_out = data_out_q;
  assign almost_empty_n_out = ae_n_q;
  assign almost_full_n_out = af_n_q;
  assign mem_wr_out = mem_wr_q;
  assign mem_rd_out = mem_rd_q;
  assign mem_wr_data_out = mem_wr_data_q;
  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // ==========================================================================
  // checks
  AST_DEFAULT_LOAD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !master_reset_n_in |=> offs_q == ($past(offset_load_n_in) ? {SER_DEFAULT, SER_DEFAULT} : {PAR_DEFAULT, PAR_DEFAULT}))
    else $error("default offsets wrong after master reset");

  AST_MODE_LATCH: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    master_reset_n_in |=> $stable(serial_q) && $stable(first_word_fall_through_q))
    else $error("load method changed outside master reset");

  AST_SERIAL_BIT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ser_shift |=> offs_q[$past(sidx_q)] == $past(serial_offset_in) && sidx_q != $past(sidx_q))
    else $error("serial bit not captured");

  AST_SERIAL_WRAP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ser_shift && sidx_q == SER_LAST |=> sidx_q == '0)
    else $error("serial sequence length wrong");

  AST_SEN_HIGH_HOLD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    master_reset_n_in && serial_q && !offset_load_n_in && serial_shift_enable_n_in
      |=> $stable(offs_q) && $stable(sidx_q))
    else $error("serial capture with shift enable high");

  AST_AF_VALID: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ser_done ##1 (!ser_shift && master_reset_n_in) [*2] |-> !af_vld_q ##1 af_vld_q)
    else $error("almost-full validity not two edges after load");

  AST_AE_VALID: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ser_done ##1 (!ser_shift && master_reset_n_in) [*3] |-> !ae_vld_q ##1 ae_vld_q)
    else $error("almost-empty validity delay wrong");

  AST_PAR_FIRST: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    par_wr && !wptr_q |=> empty_ofs == $past(data_in_bus_in[OFS_W-1:0]) && wptr_q)
    else $error("parallel write missed empty offset");

  AST_MRS_PTRS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !master_reset_n_in |=> !wptr_q && !rptr_q && sidx_q == '0)
    else $error("pointers not cleared by master reset");

  AST_PRS_PTRS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    master_reset_n_in && !partial_reset_n_in |=> $stable(wptr_q) && $stable(rptr_q) && $stable(offs_q))
    else $error("partial reset disturbed offset state");

  AST_READ_ORDER: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    off_rd |=> data_out_q == DATA_W'($past(rptr_q) ? $past(full_ofs) : $past(empty_ofs)) && rptr_q != $past(rptr_q))
    else $error("offset readback order wrong");

  AST_IDLE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    run && offset_load_n_in && write_enable_n_in && read_enable_n_in
      |=> !mem_wr_q && !mem_rd_q && $stable(offs_q) && $stable(data_out_q))
    else $error("operation while all controls idle");

endmodule

`default_nettype wire

// *** tb/host_model.sv ***
// host-side driver of the offset programming pins
// assumes clk_in is both write and read clock of the device
`timescale 1ns/1ps
`default_nettype none
module host_model
  import flag_offset_pkg::*;
(
  // clock
  input wire logic clk_in,
  // programming pins
  output logic offset_load_n_out,
  output logic serial_shift_enable_n_out,
  output logic write_enable_n_out,
  output logic read_enable_n_out,
  output logic serial_offset_out,
  output logic [DATA_W-1:0] data_in_bus_out
);
  // ==========
  // pin driver
  initial
  begin
    offset_load_n_out = 1'b1;
    serial_shift_enable_n_out = 1'b1;
    write_enable_n_out = 1'b1;
    read_enable_n_out = 1'b1;
    serial_offset_out = 1'b0;
    data_in_bus_out = '0;
  end
  // one request, launched after an edge, taken at the next
  task automatic op(input logic ld, input logic serial_shift_enable_n, input logic wen, input logic ren, input logic si,
                    input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    offset_load_n_out <= ld;
    serial_shift_enable_n_out <= serial_shift_enable_n;
    write_enable_n_out <= wen;
    read_enable_n_out <= ren | (~ld & ~wen);
    serial_offset_out <= serial_shift_enable_n ? ~serial_offset_out : si;
    data_in_bus_out <= wen ? ~data_in_bus_out : d;
  endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench of flag_offset_ctrl against an integer model
// assumes host_model owns the programming pins; bench drives the rest
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module testbench
  import flag_offset_pkg::*;
;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic mrst_n = 1'b1, prst_n = 1'b1, first_word_fall_through = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [DATA_W-1:0] mem_rd_data = '0;
  logic [CNT_W-1:0] word_count = '0;
  logic ld_n, sen_n, wen_n, ren_n, si, mem_wr, mem_rd, pready, pslverr, ae_n, af_n, er;
  logic [DATA_W-1:0] din, mem_wr_data, dout, d;
  logic [31:0] prdata, rd;
  int failures = 0, checks = 0;
  int e_ofs, f_ofs, ser, fw, wp, rp, sidx, aev, afv, b;

  initial
  begin
    forever #2.5 clk_in = ~clk_in;
  end

  host_model i_host_model (.clk_in(clk_in), .offset_load_n_out(ld_n), .serial_shift_enable_n_out(sen_n),
    .write_enable_n_out(wen_n), .read_enable_n_out(ren_n), .serial_offset_out(si), .data_in_bus_out(din));

  flag_offset_ctrl i_flag_offset_ctrl (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .master_reset_n_in(mrst_n),
    .partial_reset_n_in(prst_n), .first_word_fall_through_in(first_word_fall_through), .offset_load_n_in(ld_n),
    .serial_shift_enable_n_in(sen_n), .write_enable_n_in(wen_n), .read_enable_n_in(ren_n),
    .serial_offset_in(si), .data_in_bus_in(din), .mem_rd_data_in(mem_rd_data), .word_count_in(word_count),
    .mem_wr_out(mem_wr), .mem_rd_out(mem_rd), .mem_wr_data_out(mem_wr_data), .data_out_bus_out(dout),
    .almost_empty_n_out(ae_n), .almost_full_n_out(af_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  // ==========
  // helpers
  task automatic conclude();
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic settle();
    i_host_model.op(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, '0);
    #1;
  endtask
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_in);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input int e, input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, rd)
    `CHK("pslverr", ee, er)
  endtask
  task automatic st_chk();
    rchk(STATUS_ADDR, (sidx << ST_SIDX_LSB) | (rp << ST_RPTR_BIT) | (wp << ST_WPTR_BIT) | (afv << ST_AF_VLD_BIT)
         | (aev << ST_AE_VLD_BIT) | (fw << ST_FIRST_WORD_FALL_THROUGH_BIT) | ser, 1'b0);
    rchk(EMPTY_OFS_ADDR, e_ofs, 1'b0);
    rchk(FULL_OFS_ADDR, f_ofs, 1'b0);
  endtask
  task automatic mreset(input int l, input int f);
    i_host_model.op(l[0], 1'b1, 1'b1, 1'b1, 1'b0, '0);
    mrst_n <= 1'b0;
    first_word_fall_through <= f[0];
    repeat (2) @(posedge clk_in);
    mrst_n <= 1'b1;
    e_ofs = l ? 1023 : 127;
    f_ofs = e_ofs;
    ser = l;
    fw = f;
    {wp, rp, sidx, aev, afv} = {0, 0, 0, 1, 1};
    settle();
    repeat (4) @(posedge clk_in);
    st_chk();
  endtask
  task automatic flags(input int c);
    @(posedge clk_in);
    word_count <= c[CNT_W-1:0];
    repeat (6) @(posedge clk_in);
    #1;
    `CHK("almost_empty_n", int'(c >= e_ofs + 1 + fw), ae_n)
    `CHK("almost_full_n", int'(c < int'(DEPTH_WORDS) + fw - f_ofs), af_n)
  endtask
  task automatic fcheck();
    flags(e_ofs + fw);
    flags(e_ofs + fw + 1);
    flags(int'(DEPTH_WORDS) + fw - f_ofs - 1);
    flags(int'(DEPTH_WORDS) + fw - f_ofs);
  endtask
  task automatic rdofs(input int e);
    i_host_model.op(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, '0);
    settle();
    rp ^= 1;
    `CHK("data_out_bus", e, dout)
  endtask
  task automatic pwr(input int w);
    d = DATA_W'($urandom_range(8191, 0));
    i_host_model.op(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, d);
    if (w) e_ofs = d; else f_ofs = d;
    wp ^= 1;
  endtask

  // ==========
  // watchdog
  initial
  begin
    repeat (30000) @(posedge clk_in);
    failures++;
    conclude();
  end

  // ==========
  // tests
  initial
  begin
    void'($urandom(83));
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    {e_ofs, f_ofs, ser, fw, wp, rp, sidx, aev, afv} = {127, 127, 0, 0, 0, 0, 0, 1, 1};
    st_chk();
    rchk(CTRL_ADDR, 1, 1'b0);
    rchk(12'h010, 0, 1'b1);
    apb(1'b1, STATUS_ADDR, 32'hFFFFFFFF);
    apb(1'b1, CTRL_ADDR, 32'h0);
    repeat (3) @(posedge clk_in);
    `CHK("almost_empty_n", 1, ae_n)
    apb(1'b1, CTRL_ADDR, 32'h1);
    mreset(1, 0);
    i_host_model.op(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 18'h01555);
    settle();
    st_chk();
    for (int i = 0; i < SER_BITS; i++)
    begin
      b = $urandom_range(1, 0);
      if (i == 10)
      begin
        repeat (3) i_host_model.op(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, '0);
        i_host_model.op(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 18'h2A5A5);
        settle();
        `CHK("mem_wr", 1, mem_wr)
        {sidx, aev, afv} = {10, 0, 0};
        st_chk();
      end
      i_host_model.op(1'b0, 1'b0, 1'b1, 1'b1, b[0], '0);
      if (i < OFS_W) e_ofs[i] = b[0]; else f_ofs[i - OFS_W] = b[0];
    end
    settle();
    repeat (6) @(posedge clk_in);
    {sidx, aev, afv} = {0, 1, 1};
    st_chk();
    fcheck();
    @(posedge clk_in);
    mem_rd_data <= DATA_W'($urandom);
    i_host_model.op(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, '0);
    settle();
    `CHK("mem_read_word", mem_rd_data, dout)
    `CHK("mem_rd", 1, mem_rd)
    rdofs(e_ofs);
    rdofs(f_ofs);
    rdofs(e_ofs);
    mreset(0, 1);
    rdofs(e_ofs);
    @(posedge clk_in);
    prst_n <= 1'b0;
    @(posedge clk_in);
    prst_n <= 1'b1;
    settle();
    `CHK("data_out_bus", 0, dout)
    st_chk();
    rdofs(f_ofs);
    pwr(1);
    settle();
    repeat (6) @(posedge clk_in);
    afv = 0;
    st_chk();
    i_host_model.op(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 18'h15A3C);
    settle();
    `CHK("mem_wr_data", 18'h15A3C, mem_wr_data)
    pwr(0);
    pwr(1);
    pwr(0);
    settle();
    `CHK("mem_wr", 0, mem_wr)
    repeat (6) @(posedge clk_in);
    afv = 1;
    st_chk();
    fcheck();
    rdofs(e_ofs);
    conclude();
  end
endmodule
`default_nettype wire
